// ==== src/psld_pkg.sv ====
package psld_pkg;
    // =========================================================
    // Timing
    localparam int PSLD_CLK_NS = 50;
    localparam int PSLD_STRETCH_MS = 170;
    localparam int PSLD_BLINK_MS = 84;
    localparam int PSLD_REFRESH_MS = 42;
    localparam int PSLD_BIT_NS = 80;
    localparam int PSLD_STRETCH_CYC = PSLD_STRETCH_MS * 1000000 / PSLD_CLK_NS;
    localparam int PSLD_BLINK_CYC = PSLD_BLINK_MS * 1000000 / PSLD_CLK_NS;
    localparam int PSLD_REFRESH_CYC = PSLD_REFRESH_MS * 1000000 / PSLD_CLK_NS;
    localparam int PSLD_BIT_CYC = (PSLD_BIT_NS + PSLD_CLK_NS - 1) / PSLD_CLK_NS;
    localparam int PSLD_HALF_CYC = PSLD_BIT_CYC / 2;
    localparam logic [1:0] PSLD_STRAP_WAIT = 2'h2;
    // =========================================================
    // Sizes
    localparam int PSLD_PORTS = 6;
    localparam int PSLD_PAR_PORTS = 5;
    localparam int PSLD_ITEMS = 11;
    localparam int PSLD_POS = 22;
    localparam int PSLD_UNITS = 9;
    localparam int PSLD_LONG_UNITS = 6;
    // =========================================================
    // Registers
    localparam logic [7:0] PSLD_CTRL_OFS = 8'h00;
    localparam logic [7:0] PSLD_ITEM_OFS = 8'h04;
    localparam logic [7:0] PSLD_OVR_OFS = 8'h08;
    localparam logic [7:0] PSLD_STAT_OFS = 8'h0c;
    localparam int PSLD_STR_LSB = 0;
    localparam int PSLD_BLK_LSB = 2;
    localparam int PSLD_REF_LSB = 4;
    localparam int PSLD_PAR_LSB = 6;
    localparam int PSLD_ACTB_BIT = 8;
    localparam logic [8:0] PSLD_CTRL_RST = 9'h001;
    localparam logic [21:0] PSLD_ITEM_RST = 22'h000000;
    localparam logic [29:0] PSLD_OVR_RST = 30'h00000000;
    // =========================================================
    // Items in stream order and default sets per strap mode
    localparam int PSLD_I_COL = 0;
    localparam int PSLD_I_ERR = 1;
    localparam int PSLD_I_DUP = 2;
    localparam int PSLD_I_DUPCOL = 3;
    localparam int PSLD_I_SPD = 4;
    localparam int PSLD_I_LINK = 5;
    localparam int PSLD_I_TX = 6;
    localparam int PSLD_I_RX = 7;
    localparam int PSLD_I_ACT = 8;
    localparam int PSLD_I_LINKRX = 9;
    localparam int PSLD_I_LINKACT = 10;
    localparam logic [10:0] PSLD_ITEMS_M0 = 11'h41a;
    localparam logic [10:0] PSLD_ITEMS_M1 = 11'h257;
    localparam logic [10:0] PSLD_ITEMS_M2 = 11'h137;
    localparam logic [10:0] PSLD_ITEMS_M3 = 11'h0f7;
    localparam logic [1:0] PSLD_IM_OFF = 2'h0;
    localparam logic [1:0] PSLD_IM_SINGLE = 2'h1;
    localparam logic [1:0] PSLD_OV_NONE = 2'h0;
    localparam logic [1:0] PSLD_OV_ON = 2'h1;
    localparam logic [1:0] PSLD_OV_OFF = 2'h2;
    localparam logic [2:0] PSLD_AGE_IDLE = 3'h7;
    localparam logic [2:0] PSLD_SHORT_LIM = 3'h2;
    // =========================================================
    // Types
    typedef struct packed {
        logic link;
        logic spd100;
        logic fdx;
        logic col;
        logic tx;
        logic rx;
        logic rxer;
        logic fcar;
        logic jab;
        logic fifo;
    } psld_phy_t;
    typedef enum logic {PSLD_IDLE, PSLD_SHIFT} psld_state_t;
endpackage : psld_pkg

// ==== src/psld_top.sv ====
// Summary of operation
// - Collision pin low on collision, stretched 170 ms.
// - Error pin low on jabber, rx error, false carrier, FIFO fault; 170 ms.
// - Duplex low for full, high for half.
// - Duplex/collision shows duplex, blinks 84 ms on collisions.
// - Speed low at 100 Mbps, high at 10 Mbps.
// - Link low when up, high when down.
// - Transmit, receive, activity low when active, stretched 170 ms.
// - Link/receive shows link, blinks 84 ms on receive.
// - Activity blink variant high when idle, blinks on traffic.
// - Serial link/activity shows link, blinks on 170 ms traffic.
// - Serial link has data, strobe, clock; strap picks four modes.
// - Serial items start single or off from strap; software sets off, single or dual.
// - Single item: same data both positions, strobe over 100 only.
// - Dual item: separate data, strobe over both; off item: none.
// - Stream refreshed at programmable interval, default 42 ms.
// - Shifting pauses after each update; outer register holds.
// - Default serial item sets per strap mode.
// - Bits follow serial clock, at least 80 ns; port 5 first.
// - Items in fixed order, 100 position before 10 position.
// - Dual error splits faults per speed.
// - Dual speed positions low at their own speed.
// - Dual positions low when condition holds at that speed.
// - Parallel pins by strap mode.
// - Software forces parallel pins on, off or blinking.
// - Stretch and blink programmable, defaults 170-340 ms and 84 ms.
//
// The placing of the registers and the APB slave port were decided locally.
`timescale 1ns/10ps
module psld_top
    import psld_pkg::*;
#(
    parameter int STRETCH_CYC = PSLD_STRETCH_CYC,
    parameter int BLINK_CYC = PSLD_BLINK_CYC,
    parameter int REFRESH_CYC = PSLD_REFRESH_CYC
) (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Strap and port status.
    input wire logic [1:0] mode_strap,
    input wire psld_phy_t [PSLD_PORTS-1:0] phy_status,
    // Parallel indicator pins, low means lit.
    output logic [PSLD_PAR_PORTS-1:0] port_indicator_pin_a,
    output logic [PSLD_PAR_PORTS-1:0] port_indicator_pin_b,
    output logic [PSLD_PAR_PORTS-1:0] port_indicator_pin_c,
    // Serial indicator link.
    output logic serial_indicator_data,
    output logic serial_indicator_strobe,
    output logic serial_indicator_clock
);

    // =========================================================
    // Functions
    function automatic logic [21:0] expand(input logic [1:0] m);
        logic [10:0] s;
        logic [21:0] r;
        s = (m == 2'h0) ? PSLD_ITEMS_M0 : (m == 2'h1) ? PSLD_ITEMS_M1 :
            (m == 2'h2) ? PSLD_ITEMS_M2 : PSLD_ITEMS_M3;
        r = '0;
        for (int i = 0; i < PSLD_ITEMS; i++) begin
            r[2*i +: 2] = s[i] ? PSLD_IM_SINGLE : PSLD_IM_OFF;
        end
        return r;
    endfunction : expand

    function automatic logic force_pin(input logic [1:0] ov, input logic v,
                                       input logic blk);
        return (ov == PSLD_OV_NONE) ? v : (ov == PSLD_OV_ON) ? 1'b0 :
               (ov == PSLD_OV_OFF) ? 1'b1 : blk;
    endfunction : force_pin

    // =========================================================
    // Input synchronisers
    psld_phy_t [PSLD_PORTS-1:0] phy_m_r;
    psld_phy_t [PSLD_PORTS-1:0] phy_s_r;
    logic [1:0] strap_m_r;
    logic [1:0] strap_s_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phy_m_r <= '0;
            phy_s_r <= '0;
            strap_m_r <= 2'h0;
            strap_s_r <= 2'h0;
        end else begin
            phy_m_r <= phy_status;
            phy_s_r <= phy_m_r;
            strap_m_r <= mode_strap;
            strap_s_r <= strap_m_r;
        end
    end

    // =========================================================
    // Registers
    logic [8:0] ctrl_r;
    logic [21:0] item_r;
    logic [29:0] ovr_r;
    logic [31:0] prdata_r;
    logic [1:0] strap_cnt_r;
    logic loaded_r;
    psld_state_t state_r;
    logic [5:0] links;
    wire [1:0] str_set = ctrl_r[PSLD_STR_LSB +: 2];
    wire [1:0] blk_set = ctrl_r[PSLD_BLK_LSB +: 2];
    wire [1:0] ref_set = ctrl_r[PSLD_REF_LSB +: 2];
    wire [1:0] par_mode = ctrl_r[PSLD_PAR_LSB +: 2];
    wire act_blink = ctrl_r[PSLD_ACTB_BIT];
    wire sel_ctrl = paddr == PSLD_CTRL_OFS;
    wire sel_item = paddr == PSLD_ITEM_OFS;
    wire sel_ovr = paddr == PSLD_OVR_OFS;
    wire sel_stat = paddr == PSLD_STAT_OFS;
    wire mapped = sel_ctrl | sel_item | sel_ovr | sel_stat;
    wire wr = psel & penable & pwrite & mapped;
    wire strap_load = !loaded_r && strap_cnt_r == PSLD_STRAP_WAIT;
    wire busy = state_r == PSLD_SHIFT;
    wire [31:0] rd_mux = sel_ctrl ? 32'(ctrl_r) : sel_item ? 32'(item_r) :
        sel_ovr ? 32'(ovr_r) :
        sel_stat ? 32'({links, 4'h0, busy, loaded_r, strap_s_r}) : 32'h0;
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped;
    assign prdata = prdata_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= PSLD_CTRL_RST;
            item_r <= PSLD_ITEM_RST;
            ovr_r <= PSLD_OVR_RST;
            strap_cnt_r <= 2'h0;
            loaded_r <= 1'b0;
            prdata_r <= 32'h0;
        end else begin
            prdata_r <= (psel & ~penable) ? rd_mux : prdata_r;
            strap_cnt_r <= loaded_r ? strap_cnt_r : strap_cnt_r + 2'h1;
            if (strap_load) begin
                ctrl_r[PSLD_PAR_LSB +: 2] <= strap_s_r;
                item_r <= expand(strap_s_r);
                loaded_r <= 1'b1;
            end else if (wr && sel_ctrl) begin
                ctrl_r <= pwdata[8:0];
            end else if (wr && sel_item) begin
                item_r <= pwdata[21:0];
            end else if (wr && sel_ovr) begin
                ovr_r <= pwdata[29:0];
            end
        end
    end

    // =========================================================
    // Stretch, blink and refresh timers
    logic [23:0] str_cnt_r;
    logic [23:0] blk_cnt_r;
    logic [23:0] ref_cnt_r;
    logic blink_r;
    wire [23:0] blk_lim = 24'(BLINK_CYC * (int'(blk_set) + 1) - 1);
    wire [23:0] ref_lim = 24'(REFRESH_CYC * (int'(ref_set) + 1) - 1);
    wire str_tick = str_cnt_r >= 24'(STRETCH_CYC - 1);
    wire blk_tick = blk_cnt_r >= blk_lim;
    wire ref_tick = ref_cnt_r >= ref_lim;
    wire [2:0] str_lim = {str_set, 1'b0};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            str_cnt_r <= 24'h0;
            blk_cnt_r <= 24'h0;
            ref_cnt_r <= 24'h0;
            blink_r <= 1'b0;
        end else begin
            str_cnt_r <= str_tick ? 24'h0 : str_cnt_r + 24'h1;
            blk_cnt_r <= blk_tick ? 24'h0 : blk_cnt_r + 24'h1;
            ref_cnt_r <= ref_tick ? 24'h0 : ref_cnt_r + 24'h1;
            blink_r <= blink_r ^ blk_tick;
        end
    end

    // =========================================================
    // Per-port status, stretching and encoding
    logic [PSLD_POS-1:0] pdat [PSLD_PORTS];
    logic [PSLD_POS-1:0] pen [PSLD_PORTS];
    logic [PSLD_PAR_PORTS-1:0][2:0] pin_nxt;
    logic [PSLD_PAR_PORTS-1:0][2:0] pin_r;
    for (genvar p = 0; p < PSLD_PORTS; p++) begin : g_port
        psld_phy_t s;
        logic [8:0] ev;
        logic [8:0] st;
        logic [10:0] sv;
        logic [10:0] d100;
        logic [10:0] d10;
        assign s = phy_s_r[p];
        assign links[p] = s.link;
        assign ev = {s.tx | s.rx, s.rx, s.col, s.tx | s.rx, s.rx, s.tx,
                     s.jab | (s.fifo & ~s.spd100),
                     s.rxer | s.fcar | (s.fifo & s.spd100), s.col};
        for (genvar u = 0; u < PSLD_UNITS; u++) begin : g_unit
            logic [2:0] age_r;
            logic [2:0] age_nxt;
            wire tick = (u < PSLD_LONG_UNITS) ? str_tick : blk_tick;
            wire [2:0] lim = (u < PSLD_LONG_UNITS) ? str_lim : PSLD_SHORT_LIM;
            wire held = age_r != PSLD_AGE_IDLE;
            wire done = lim == 3'h0 || (tick && age_r + 3'h1 >= lim);
            assign age_nxt = ev[u] ? 3'h0 : !held ? age_r :
                done ? PSLD_AGE_IDLE : tick ? age_r + 3'h1 : age_r;
            assign st[u] = ev[u] | held;
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    age_r <= PSLD_AGE_IDLE;
                end else begin
                    age_r <= age_nxt;
                end
            end
        end
        // Single-mode values, low means lit.
        assign sv[PSLD_I_COL] = ~st[0];
        assign sv[PSLD_I_ERR] = ~(st[1] | st[2]);
        assign sv[PSLD_I_DUP] = ~s.fdx;
        assign sv[PSLD_I_DUPCOL] = st[6] ? blink_r : ~s.fdx;
        assign sv[PSLD_I_SPD] = ~s.spd100;
        assign sv[PSLD_I_LINK] = ~s.link;
        assign sv[PSLD_I_TX] = ~st[3];
        assign sv[PSLD_I_RX] = ~st[4];
        assign sv[PSLD_I_ACT] = ~st[5];
        assign sv[PSLD_I_LINKRX] = st[7] ? blink_r : ~s.link;
        assign sv[PSLD_I_LINKACT] = st[5] ? blink_r : ~s.link;
        for (genvar i = 0; i < PSLD_ITEMS; i++) begin : g_item
            wire dual = item_r[2*i+1];
            assign d100[i] = (i == PSLD_I_ERR) ? ~st[1] :
                (i == PSLD_I_SPD) ? ~s.spd100 :
                s.spd100 ? sv[i] : 1'b1;
            assign d10[i] = (i == PSLD_I_ERR) ? ~st[2] :
                (i == PSLD_I_SPD) ? s.spd100 :
                s.spd100 ? 1'b1 : sv[i];
            assign pdat[p][2*i] = dual ? d100[i] : sv[i];
            assign pdat[p][2*i+1] = dual ? d10[i] : sv[i];
            assign pen[p][2*i] = item_r[2*i +: 2] != PSLD_IM_OFF;
            assign pen[p][2*i+1] = dual;
        end
        if (p < PSLD_PAR_PORTS) begin : g_par
            logic [2:0] pv;
            wire actb = st[8] ? blink_r : 1'b1;
            wire actv = act_blink ? actb : sv[PSLD_I_ACT];
            assign pv = (par_mode == 2'h0) ?
                    {sv[PSLD_I_LINK], sv[PSLD_I_RX], sv[PSLD_I_TX]} :
                (par_mode == 2'h1) ?
                    {sv[PSLD_I_LINK], actv, sv[PSLD_I_SPD]} :
                (par_mode == 2'h2) ?
                    {sv[PSLD_I_LINKRX], sv[PSLD_I_TX], sv[PSLD_I_SPD]} :
                    {sv[PSLD_I_LINKACT], sv[PSLD_I_DUPCOL], sv[PSLD_I_SPD]};
            for (genvar j = 0; j < 3; j++) begin : g_pin
                assign pin_nxt[p][j] =
                    force_pin(ovr_r[(p*3+j)*2 +: 2], pv[j], blink_r);
            end
            assign port_indicator_pin_a[p] = pin_r[p][0];
            assign port_indicator_pin_b[p] = pin_r[p][1];
            assign port_indicator_pin_c[p] = pin_r[p][2];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_r <= '1;
        end else begin
            pin_r <= pin_nxt;
        end
    end

    // =========================================================
    // Serial stream
    logic [2:0] port_r;
    logic [4:0] pos_r;
    logic [3:0] bit_cnt_r;
    logic data_r;
    logic ena_r;
    logic clk_r;
    wire d_cur = pdat[port_r][pos_r];
    wire en_cur = pen[port_r][pos_r];
    wire bit_end = bit_cnt_r == 4'(PSLD_BIT_CYC - 1);
    wire last_bit = pos_r == 5'(PSLD_POS - 1);
    wire start = state_r == PSLD_IDLE && ref_tick && loaded_r;
    assign serial_indicator_data = data_r;
    assign serial_indicator_strobe = ena_r;
    assign serial_indicator_clock = clk_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= PSLD_IDLE;
            port_r <= 3'h0;
            pos_r <= 5'h0;
            bit_cnt_r <= 4'h0;
            data_r <= 1'b0;
            ena_r <= 1'b0;
            clk_r <= 1'b0;
        end else if (state_r == PSLD_IDLE) begin
            data_r <= 1'b0;
            ena_r <= 1'b0;
            clk_r <= 1'b0;
            bit_cnt_r <= 4'h0;
            pos_r <= 5'h0;
            port_r <= 3'(PSLD_PORTS - 1);
            state_r <= start ? PSLD_SHIFT : PSLD_IDLE;
        end else begin
            if (bit_cnt_r == 4'h0) begin
                data_r <= d_cur;
                ena_r <= en_cur;
            end
            clk_r <= bit_cnt_r >= 4'(PSLD_HALF_CYC);
            bit_cnt_r <= bit_end ? 4'h0 : bit_cnt_r + 4'h1;
            if (bit_end) begin
                pos_r <= last_bit ? 5'h0 : pos_r + 5'h1;
                port_r <= last_bit ? port_r - 3'h1 : port_r;
                if (last_bit && port_r == 3'h0) begin
                    state_r <= PSLD_IDLE;
                end
            end
        end
    end

    // =========================================================
    // Assertions
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    wire sh0 = busy && bit_cnt_r == 4'h0 && !pos_r[0];
    wire [1:0] cur_mode = item_r[2*(pos_r >> 1) +: 2];
    sequence strobe_two;
        serial_indicator_strobe [*2];
    endsequence

    idle_quiet_a: assert property (!busy |=> !clk_r && !ena_r)
        else $error("serial link not quiet while idle");
    clk_pulse_a: assert property ($rose(clk_r) |=> $fell(clk_r))
        else $error("serial clock high longer than half a bit");
    start_order_a: assert property (start |=> busy && port_r == 3'h5
        && pos_r == 5'h0) else $error("stream did not start at port 5");
    single_strb_a: assert property (sh0 && cur_mode == PSLD_IM_SINGLE
        |=> strobe_two ##1 !serial_indicator_strobe)
        else $error("single item strobe not one bit");
    dual_strb_a: assert property (sh0 && cur_mode[1]
        |=> strobe_two ##1 strobe_two)
        else $error("dual item strobe not two bits");
    off_strb_a: assert property (sh0 && cur_mode == PSLD_IM_OFF
        |=> !serial_indicator_strobe [*4])
        else $error("strobe raised over an item that is off");
    single_same_a: assert property (busy && cur_mode == PSLD_IM_SINGLE
        |-> pdat[port_r][{pos_r[4:1], 1'b0}] ==
            pdat[port_r][{pos_r[4:1], 1'b1}])
        else $error("single item positions differ");
    col_hold_a: assert property ($fell(g_port[0].ev[0]) && str_set != 2'h0
        |-> g_port[0].st[0] [*8]) else $error("collision not stretched");
    force_on_a: assert property (ovr_r[1:0] == PSLD_OV_ON
        |=> !port_indicator_pin_a[0]) else $error("forced pin not lit");
    link_pin_a: assert property (par_mode == 2'h0 &&
        ovr_r[5:4] == PSLD_OV_NONE |=> port_indicator_pin_c[0] ==
        !$past(phy_s_r[0].link)) else $error("link pin wrong");
    speed_pin_a: assert property (par_mode != 2'h0 &&
        ovr_r[1:0] == PSLD_OV_NONE |=> port_indicator_pin_a[0] ==
        !$past(phy_s_r[0].spd100)) else $error("speed pin wrong");
    strap_cap_a: assert property (strap_load |=>
        par_mode == $past(strap_s_r) && item_r == expand($past(strap_s_r)))
        else $error("strap mode not captured");
    boot_quiet_a: assert property (!loaded_r |-> !busy && !ena_r)
        else $error("stream before strap capture");

endmodule : psld_top

// ==== sim/psld_shift_model.sv ====
`timescale 1ns/10ps
module psld_shift_model (
    // Serial indicator link from the block.
    input wire logic serial_indicator_data,
    input wire logic serial_indicator_strobe,
    input wire logic serial_indicator_clock
);
    // ==========================================================
    // Outer shift register
    int n_clk = 0;
    int n_en = 0;
    logic [63:0] sr = '0;
    realtime last_t = 0;
    realtime min_gap = 1000;
    // The register only moves while the strobe enables it.
    always @(posedge serial_indicator_clock) begin
        n_clk++;
        if (n_clk > 1 && $realtime - last_t < min_gap)
            min_gap = $realtime - last_t;
        last_t = $realtime;
        if (serial_indicator_strobe === 1'b1) begin
            sr = {sr[62:0], serial_indicator_data};
            n_en++;
        end
    end
endmodule : psld_shift_model

// ==== sim/tb_port_status_led_driver.sv ====
`timescale 1ns/10ps
module tb_port_status_led_driver
    import psld_pkg::*;
();
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [1:0] mode_strap = 2'h1;
    psld_phy_t [PSLD_PORTS-1:0] phy = '0;
    logic [4:0] pin_a;
    logic [4:0] pin_b;
    logic [4:0] pin_c;
    logic s_data;
    logic s_strobe;
    logic s_clock;
    logic [31:0] rd;
    logic slv;
    int errors = 0;
    int check_count = 0;
    int c0;
    int e0;
    logic [31:0] item_v [3] = '{32'h41115, 32'h41116, 32'h41114};
    int en_v [3] = '{36, 42, 30};

    psld_top #(.STRETCH_CYC(20), .BLINK_CYC(10), .REFRESH_CYC(400)) DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .mode_strap(mode_strap),
        .phy_status(phy), .port_indicator_pin_a(pin_a),
        .port_indicator_pin_b(pin_b), .port_indicator_pin_c(pin_c),
        .serial_indicator_data(s_data), .serial_indicator_strobe(s_strobe),
        .serial_indicator_clock(s_clock)
    );

    psld_shift_model m (
        .serial_indicator_data(s_data),
        .serial_indicator_strobe(s_strobe),
        .serial_indicator_clock(s_clock)
    );

    initial begin
        forever #25 pclk = ~pclk;
    end

    // ==========================================================
    // Tasks
    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : test_done

    task automatic tmo;
        errors++;
        $display("mismatch at %0t: got %h expected %h", $time, 0, 1);
        test_done();
    endtask : tmo

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
            if (k > 20) tmo();
        end while (pready !== 1'b1);
        rd = prdata;
        slv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Measures one whole frame that starts after the block is idle.
    task automatic frame(input int exp_en);
        int k;
        for (k = 0; m.n_clk % 132 != 0; k++) begin
            if (k > 2000) tmo();
            @(posedge pclk);
        end
        c0 = m.n_clk;
        e0 = m.n_en;
        for (k = 0; m.n_clk != c0 + 132; k++) begin
            if (k > 2000) tmo();
            @(posedge pclk);
        end
        repeat (30) @(posedge pclk);
        chk(m.n_clk - c0, 132);
        chk(m.n_en - e0, exp_en);
    endtask : frame

    // ==========================================================
    // Main sequence
    initial begin
        repeat (10) @(negedge pclk);
        chk({pin_c[0], pin_b[0], pin_a[0], s_data, s_strobe, s_clock},
            6'h38);
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        repeat (6) @(posedge pclk);
        chk(m.n_clk, 0);
        apb(1'b0, PSLD_CTRL_OFS, 32'h0);
        chk(rd, 32'h41);
        apb(1'b0, PSLD_ITEM_OFS, 32'h0);
        chk(rd, 32'h41115);
        apb(1'b0, PSLD_STAT_OFS, 32'h0);
        chk(rd, 32'h5);
        apb(1'b0, 8'h10, 32'h0);
        chk({slv, rd}, 33'h100000000);
        $display("reset and registers done");
        @(posedge pclk);
        phy[0].link <= 1'b1;
        phy[0].spd100 <= 1'b1;
        phy[5].link <= 1'b1;
        repeat (6) @(negedge pclk);
        chk({pin_c[1], pin_c[0]}, 2'h2);
        chk({pin_a[1], pin_a[0]}, 2'h2);
        @(posedge pclk);
        phy[0].tx <= 1'b1;
        phy[0].col <= 1'b1;
        @(posedge pclk);
        phy[0].tx <= 1'b0;
        phy[0].col <= 1'b0;
        repeat (15) @(negedge pclk);
        chk(pin_b[0], 1'b0);
        repeat (85) @(negedge pclk);
        chk(pin_b[0], 1'b1);
        apb(1'b1, PSLD_OVR_OFS, 32'h81);
        repeat (4) @(negedge pclk);
        chk({pin_a[1], pin_a[0]}, 2'h2);
        apb(1'b1, PSLD_OVR_OFS, 32'h0);
        apb(1'b1, PSLD_CTRL_OFS, 32'h109);
        apb(1'b0, PSLD_CTRL_OFS, 32'h0);
        chk(rd, 32'h109);
        repeat (4) @(negedge pclk);
        chk({pin_c[1], pin_c[0], pin_a[1], pin_a[0]}, 4'hb);
        $display("parallel pins done");
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, PSLD_ITEM_OFS, item_v[i]);
            frame(en_v[i]);
            if (i == 0)
                chk(m.sr[35:0], {6'h3e, 24'hffffff, 6'h3a});
        end
        chk(m.min_gap >= 80.0, 1'b1);
        $display("serial stream done");
        test_done();
    end
endmodule : tb_port_status_led_driver
